// File: verilog/xod_decoder.sv
// Purpose: decode one instruction and look up its execute clock counts
// Assumes: ib0..ib2 hold the first three instruction bytes, prefixes removed
// Notes:   one registered stage; accepts a new instruction every cycle
`timescale 1ns/10ps

module xod_decoder (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // instruction in
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [7:0]       ib0,
  input  wire logic [7:0]       ib1,
  input  wire logic [7:0]       ib2,
  input  wire logic             prot_mode,
  input  wire logic             opsize32,
  input  wire logic             addrsize32,
  // decode result
  output logic                  dec_valid,
  output logic                  dec_hit,
  output logic                  dec_invalid,
  output xod_pkg::xod_class_t   dec_class,
  output logic [6:0]            dec_clk_min,
  output logic [6:0]            dec_clk_max,
  output logic                  dec_flags_mod,
  output logic                  dec_has_modrm,
  output logic [2:0]            dec_opnd_len,
  output logic [2:0]            dec_imm_len,
  output logic [2:0]            dec_disp_len,
  output logic [3:0]            dec_insn_len
);
  import xod_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // field helpers

  function automatic logic [1:0] f_mod(input logic [7:0] m);
    f_mod = m[7:6];
  endfunction

  function automatic logic [2:0] f_reg(input logic [7:0] m);
    f_reg = m[5:3];
  endfunction

  // w bit: byte when clear, 16 or 32 bits by operand size when set
  function automatic logic [2:0] f_width(input logic w, input logic sz32);
    f_width = !w ? LEN_BYTE : (sz32 ? LEN_DWORD : LEN_WORD);
  endfunction

  // displacement implied by a modr/m byte
  function automatic logic [2:0] f_disp(input logic [7:0] m, input logic a32);
    logic [2:0] r;
    r = LEN_NONE;
    case (m[7:6])
      2'h1: r = LEN_BYTE;
      2'h2: r = a32 ? LEN_DWORD : LEN_WORD;
      2'h0: begin
        if (a32 && m[2:0] == 3'h5) begin
          r = LEN_DWORD;
        end else if (!a32 && m[2:0] == 3'h6) begin
          r = LEN_WORD;
        end
      end
      default: r = LEN_NONE;
    endcase
    f_disp = r;
  endfunction

  // eee values that name no register for a system move
  function automatic logic f_sys_bad(input logic [7:0] op, input logic [2:0] e);
    logic b;
    b = 1'b0;
    case (op)
      OP_CR_WRITE, OP_CR_READ: b = !(e == 3'h0 || e == 3'h2 || e == 3'h3);
      OP_DR_WRITE, OP_DR_READ: b = (e == 3'h4 || e == 3'h5);
      OP_TR_WRITE, OP_TR_READ: b = (e < 3'h3);
      default: b = 1'b1;
    endcase
    f_sys_bad = b;
  endfunction

  // execute count of a system move, same in both modes
  function automatic logic [6:0] f_sys_clk(input logic [7:0] op, input logic [2:0] e);
    logic [6:0] c;
    c = CLK_ONE;
    case (op)
      OP_CR_WRITE: c = (e == 3'h0) ? CLK_CR0_WRITE : CLK_CR23_WRITE;
      OP_CR_READ:  c = CLK_CR_READ;
      OP_DR_WRITE: c = CLK_DR_WRITE;
      OP_DR_READ:  c = CLK_DR_READ;
      OP_TR_WRITE: c = CLK_TR_WRITE;
      OP_TR_READ:  c = (e >= 3'h6) ? CLK_TRT_READ : CLK_TRC_READ;
      default:     c = CLK_ONE;
    endcase
    f_sys_clk = c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // combinational decode

  xod_class_t cls;
  logic       hit;
  logic       bad;
  logic       real_ok;
  logic [6:0] c_real;
  logic [6:0] c_pmin;
  logic [6:0] c_pmax;
  logic       flags_mod;
  logic       modrm;
  logic [7:0] mrm;
  logic [2:0] opnd;
  logic [2:0] imm;
  logic [2:0] disp;
  logic [2:0] eee;
  logic       esc;
  logic [3:0] len_d;

  // no buffer: the result register takes a new word every cycle
  assign in_ready = 1'b1;

  assign esc = (ib0 == OP_ESC);
  assign mrm = esc ? ib2 : ib1;
  assign eee = f_reg(ib2);

  always_comb begin
    cls       = XOD_NONE;
    hit       = 1'b1;
    bad       = 1'b0;
    real_ok   = 1'b1;
    c_real    = CLK_ONE;
    c_pmin    = CLK_ONE;
    c_pmax    = CLK_ONE;
    flags_mod = 1'b0;
    modrm     = 1'b0;
    opnd      = opsize32 ? LEN_DWORD : LEN_WORD;
    imm       = LEN_NONE;
    disp      = LEN_NONE;
    if (esc) begin
      modrm = 1'b1;
      if (ib1 == OP_SEG_LIMIT) begin
        cls       = XOD_SEG_LIMIT_LOAD;
        real_ok   = 1'b0;
        c_pmin    = CLK_SEG_LIMIT;
        c_pmax    = CLK_SEG_LIMIT;
        flags_mod = 1'b1;
      end else if (ib1 == OP_SS_FAR) begin
        cls    = XOD_STACK_POINTER_FAR_LOAD;
        c_real = CLK_SS_REAL;
        c_pmin = CLK_SS_PROT;
        c_pmax = CLK_SS_PROT;
      end else if (ib1 == OP_GRP_SYS && f_reg(ib2) == REG_TASK_LOAD) begin
        cls     = XOD_TASK_REGISTER_LOAD;
        real_ok = 1'b0;
        c_pmin  = CLK_TASK_LOAD;
        c_pmax  = CLK_TASK_LOAD;
        opnd    = LEN_WORD;
      end else if (ib1 == OP_CR_WRITE || ib1 == OP_CR_READ) begin
        cls    = (ib1 == OP_CR_WRITE) ? XOD_CR_WRITE : XOD_CR_READ;
        c_real = f_sys_clk(ib1, eee);
        bad    = f_sys_bad(ib1, eee);
        opnd   = LEN_DWORD;
      end else if (ib1 == OP_DR_WRITE || ib1 == OP_DR_READ) begin
        // status and control pair share counts
        cls    = (ib1 == OP_DR_WRITE) ? XOD_DR_WRITE : XOD_DR_READ;
        c_real = f_sys_clk(ib1, eee);
        bad    = f_sys_bad(ib1, eee);
        opnd   = LEN_DWORD;
      end else if (ib1 == OP_TR_WRITE || ib1 == OP_TR_READ) begin
        cls    = (ib1 == OP_TR_WRITE) ? XOD_TR_WRITE : XOD_TR_READ;
        c_real = f_sys_clk(ib1, eee);
        bad    = f_sys_bad(ib1, eee);
        opnd   = LEN_DWORD;
      end else if (ib1[7:1] == OP_SX_MOVE) begin
        cls = XOD_SIGN_EXTENDING_MOVE;
      end else if (ib1[7:1] == OP_ZX_MOVE) begin
        cls = XOD_ZERO_EXTENDING_MOVE;
      end else if (ib1 == OP_RESV_INV) begin
        // reserved opcode, range in protected mode
        cls       = XOD_RESERVED_INVALID_OPCODE;
        modrm     = 1'b0;
        c_pmin    = CLK_RESV_PMIN;
        c_pmax    = CLK_RESV_PMAX;
        flags_mod = 1'b1;
        bad       = 1'b1;
      end else begin
        hit   = 1'b0;
        modrm = 1'b0;
      end
      // system register moves exist only with a register-mode modr/m
      if (cls inside {XOD_CR_WRITE, XOD_CR_READ, XOD_DR_WRITE, XOD_DR_READ,
                      XOD_TR_WRITE, XOD_TR_READ}) begin
        c_pmin = c_real;
        c_pmax = c_real;
        if (f_mod(ib2) != MOD_REG) begin
          bad = 1'b1;
        end
      end
    end else if (ib0[7:2] == OP_MOV_RM) begin
      cls   = XOD_DATA_MOVE;
      modrm = 1'b1;
      opnd  = f_width(ib0[0], opsize32);
    end else if (ib0 == OP_SREG_LOAD) begin
      // 1 real, 1 or 3 protected
      cls    = XOD_SREG_LOAD;
      modrm  = 1'b1;
      c_pmax = CLK_SREG_PMAX;
      opnd   = LEN_WORD;
      bad    = (f_reg(ib1) > SREG_LAST);
    end else if (ib0 == OP_SREG_STORE) begin
      cls   = XOD_SREG_STORE;
      modrm = 1'b1;
      opnd  = LEN_WORD;
      bad   = (f_reg(ib1) > SREG_LAST);
    end else if (ib0[7:1] == OP_MOV_IMM_RM && f_reg(ib1) == REG_IMM_MOV) begin
      cls   = XOD_MOVE_IMM;
      modrm = 1'b1;
      opnd  = f_width(ib0[0], opsize32);
      imm   = opnd;
    end else if (ib0[7:4] == OP_MOV_IMM_R) begin
      cls  = XOD_MOVE_IMM;
      opnd = f_width(ib0[3], opsize32);
      imm  = opnd;
    end else if (ib0[7:2] == OP_MOV_ACC) begin
      cls  = XOD_MOVE_ACC;
      opnd = f_width(ib0[0], opsize32);
      disp = addrsize32 ? LEN_DWORD : LEN_WORD;
    end else if (ib0[7:1] == OP_GRP_UNARY && f_reg(ib1) == REG_UMUL) begin
      cls       = XOD_UNSIGNED_MULTIPLY;
      modrm     = 1'b1;
      opnd      = f_width(ib0[0], opsize32);
      c_real    = (opnd == LEN_DWORD) ? CLK_UMUL_DWORD : CLK_UMUL_SHORT;
      c_pmin    = c_real;
      c_pmax    = c_real;
      flags_mod = 1'b1;
    end else if (ib0[7:1] == OP_GRP_UNARY && f_reg(ib1) == REG_NOT) begin
      cls   = XOD_COMPLEMENT;
      modrm = 1'b1;
      opnd  = f_width(ib0[0], opsize32);
    end else begin
      hit = 1'b0;
    end
    if (modrm) begin
      disp = f_disp(mrm, addrsize32);
    end
    // no real-mode count means invalid in real mode
    if (!prot_mode && !real_ok) begin
      bad = 1'b1;
    end
    if (!hit) begin
      c_real = CLK_ONE;
      c_pmin = CLK_ONE;
      c_pmax = CLK_ONE;
      opnd   = LEN_NONE;
    end
  end

  // total bytes, sib not counted: a 32-bit sib form is reported short by one
  assign len_d = (esc ? 4'h2 : 4'h1) + {3'h0, modrm} + {1'b0, imm} + {1'b0, disp};

  ////////////////////////////////////////////////////////////////////////////
  // result register

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dec_valid <= 1'b0;
    end else begin
      dec_valid <= in_valid;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dec_hit       <= 1'b0;
      dec_invalid   <= 1'b0;
      dec_flags_mod <= 1'b0;
    end else if (in_valid) begin
      dec_hit       <= hit;
      dec_invalid   <= hit && bad;
      dec_flags_mod <= hit && flags_mod;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dec_class <= XOD_NONE;
    end else if (in_valid) begin
      dec_class <= cls;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dec_clk_min <= 7'h00;
      dec_clk_max <= 7'h00;
    end else if (in_valid) begin
      dec_clk_min <= prot_mode ? c_pmin : c_real;
      dec_clk_max <= prot_mode ? c_pmax : c_real;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dec_has_modrm <= 1'b0;
      dec_opnd_len  <= LEN_NONE;
      dec_imm_len   <= LEN_NONE;
      dec_disp_len  <= LEN_NONE;
    end else if (in_valid) begin
      dec_has_modrm <= modrm;
      dec_opnd_len  <= opnd;
      dec_imm_len   <= imm;
      dec_disp_len  <= disp;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dec_insn_len <= 4'h0;
    end else if (in_valid) begin
      dec_insn_len <= hit ? len_d : 4'h0;
    end
  end

endmodule

// File: verilog/xod_pkg.sv
// Purpose: constants and types for the opcode decode and clock-count lookup
// Assumes: bytes of one instruction arrive together; prefixes already stripped
// Notes:   counts are for register operands or cache hits
//
// Summary of operation
// - 0F 03 with ModR/M is segment limit load, 8 protected clocks, flags modified.
// - 0F B2 with ModR/M is far pointer load to stack segment, 2 real, 4 protected.
// - 0F 00 with reg 011 is task register load, 7 clocks, protected only.
// - register-mode data move 88..8B takes 1 clock in both modes.
// - 8E segment register load takes 1 real clock, 1 or 3 protected.
// - 8C segment register store takes 1 clock in both modes.
// - B0..BF immediate to register move completes in 1 clock.
// - A0..A3 accumulator moves with full displacement complete in 1 clock.
// - 0F 22 writes control register 0, 2, 3 in 20, 5, 5 clocks.
// - 0F 20 reads control register 0, 2, 3 in 6 clocks.
// - debug registers 0..3: writes 16 clocks, reads 14 clocks.
// - test registers 3..5: writes via 0F 26 take 10, reads take 5.
// - test registers 6 and 7: writes take 10, reads take 6.
// - 0F BE/BF sign extending move takes 1 clock.
// - 0F B6/B7 zero extending move takes 1 clock.
// - F6/F7 reg 100 unsigned multiply: 4 clocks byte/word, 10 doubleword.
// - F6/F7 reg 010 boolean complement: 1 clock, flags unchanged.
// - 0F FF reserved invalid opcode: 1 real, 8 to 125 protected, flags modified.
// - immediates are 1, 2, or operand-size 1/2/4 bytes.
// - displacements are 1 signed byte or 2/4 bytes by address size.

package xod_pkg;

  // opcode bytes
  localparam logic [7:0] OP_ESC        = 8'h0f;
  localparam logic [7:0] OP_SEG_LIMIT  = 8'h03;
  localparam logic [7:0] OP_SS_FAR     = 8'hb2;
  localparam logic [7:0] OP_GRP_SYS    = 8'h00;
  localparam logic [7:0] OP_CR_READ    = 8'h20;
  localparam logic [7:0] OP_DR_READ    = 8'h21;
  localparam logic [7:0] OP_CR_WRITE   = 8'h22;
  localparam logic [7:0] OP_DR_WRITE   = 8'h23;
  localparam logic [7:0] OP_TR_READ    = 8'h24;
  localparam logic [7:0] OP_TR_WRITE   = 8'h26;
  localparam logic [7:0] OP_RESV_INV   = 8'hff;
  localparam logic [7:0] OP_SREG_LOAD  = 8'h8e;
  localparam logic [7:0] OP_SREG_STORE = 8'h8c;
  localparam logic [6:0] OP_MOV_IMM_RM = 7'h63; // c6/c7
  localparam logic [6:0] OP_GRP_UNARY  = 7'h7b; // f6/f7
  localparam logic [5:0] OP_MOV_RM     = 6'h22; // 88..8b
  localparam logic [5:0] OP_MOV_ACC    = 6'h28; // a0..a3
  localparam logic [3:0] OP_MOV_IMM_R  = 4'hb;  // b0..bf
  localparam logic [6:0] OP_ZX_MOVE    = 7'h5b; // 0f b6/b7
  localparam logic [6:0] OP_SX_MOVE    = 7'h5f; // 0f be/bf

  // modr/m reg and mod field selectors
  localparam logic [2:0] REG_TASK_LOAD = 3'h3;
  localparam logic [2:0] REG_UMUL      = 3'h4;
  localparam logic [2:0] REG_NOT       = 3'h2;
  localparam logic [2:0] REG_IMM_MOV   = 3'h0;
  localparam logic [2:0] SREG_LAST     = 3'h5;
  localparam logic [1:0] MOD_REG       = 2'h3;

  // clock counts
  localparam logic [6:0] CLK_ONE        = 7'h01;
  localparam logic [6:0] CLK_SEG_LIMIT  = 7'h08;
  localparam logic [6:0] CLK_SS_REAL    = 7'h02;
  localparam logic [6:0] CLK_SS_PROT    = 7'h04;
  localparam logic [6:0] CLK_TASK_LOAD  = 7'h07;
  localparam logic [6:0] CLK_SREG_PMAX  = 7'h03;
  localparam logic [6:0] CLK_CR0_WRITE  = 7'h14;
  localparam logic [6:0] CLK_CR23_WRITE = 7'h05;
  localparam logic [6:0] CLK_CR_READ    = 7'h06;
  localparam logic [6:0] CLK_DR_WRITE   = 7'h10;
  localparam logic [6:0] CLK_DR_READ    = 7'h0e;
  localparam logic [6:0] CLK_TR_WRITE   = 7'h0a;
  localparam logic [6:0] CLK_TRC_READ   = 7'h05;
  localparam logic [6:0] CLK_TRT_READ   = 7'h06;
  localparam logic [6:0] CLK_UMUL_SHORT = 7'h04;
  localparam logic [6:0] CLK_UMUL_DWORD = 7'h0a;
  localparam logic [6:0] CLK_RESV_PMIN  = 7'h08;
  localparam logic [6:0] CLK_RESV_PMAX  = 7'h7d;

  // field sizes in bytes
  localparam logic [2:0] LEN_NONE  = 3'h0;
  localparam logic [2:0] LEN_BYTE  = 3'h1;
  localparam logic [2:0] LEN_WORD  = 3'h2;
  localparam logic [2:0] LEN_DWORD = 3'h4;

  typedef enum logic [4:0] {
    XOD_NONE, XOD_SEG_LIMIT_LOAD, XOD_STACK_POINTER_FAR_LOAD, XOD_TASK_REGISTER_LOAD,
    XOD_DATA_MOVE, XOD_SREG_LOAD, XOD_SREG_STORE, XOD_MOVE_IMM, XOD_MOVE_ACC,
    XOD_CR_WRITE, XOD_CR_READ, XOD_DR_WRITE, XOD_DR_READ, XOD_TR_WRITE, XOD_TR_READ,
    XOD_SIGN_EXTENDING_MOVE, XOD_ZERO_EXTENDING_MOVE, XOD_UNSIGNED_MULTIPLY,
    XOD_COMPLEMENT, XOD_RESERVED_INVALID_OPCODE
  } xod_class_t;

endpackage

// File: test/xod_decoder_assertions.sv
// Purpose: port-level checks on the opcode decoder
// Assumes: one result per taken request, one cycle later
// Notes:   counts compared against literal values, opcodes against the package constants except the f7 byte in the multiply check
`timescale 1ns/10ps

module xod_decoder_assertions
  import xod_pkg::*;
(
  // clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // instruction in
  input wire logic       in_valid,
  input wire logic       in_ready,
  input wire logic [7:0] ib0,
  input wire logic [7:0] ib1,
  input wire logic [7:0] ib2,
  input wire logic       prot_mode,
  input wire logic       opsize32,
  // decode result
  input wire logic       dec_valid,
  input wire logic       dec_hit,
  input wire logic       dec_invalid,
  input wire xod_class_t dec_class,
  input wire logic [6:0] dec_clk_min,
  input wire logic [6:0] dec_clk_max,
  input wire logic       dec_flags_mod,
  input wire logic [3:0] dec_insn_len
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  valid_latency_a: assert property (in_valid |=> dec_valid)
    else $error("result did not follow a taken request");
  idle_hold_a: assert property (!in_valid |=> !dec_valid && $stable(dec_clk_max)
    && $stable(dec_class)) else $error("result moved without a request");
  ready_high_a: assert property (in_ready) else $error("ready dropped");
  count_order_a: assert property (dec_hit |-> dec_clk_min <= dec_clk_max)
    else $error("minimum count above maximum");
  miss_empty_a: assert property (dec_valid && !dec_hit |-> dec_class == XOD_NONE
    && dec_insn_len == 4'h0) else $error("miss reported a class");
  cr0_write_a: assert property (in_valid && ib0 == OP_ESC && ib1 == OP_CR_WRITE
    && ib2[7:3] == 5'h18 |=> dec_clk_max == 7'h14 && dec_class == XOD_CR_WRITE)
    else $error("control register 0 write count wrong");
  resv_cost_a: assert property (in_valid && ib0 == OP_ESC && ib1 == OP_RESV_INV
    |=> dec_invalid && dec_flags_mod && dec_clk_max == ($past(prot_mode) ? 7'h7d : 7'h01))
    else $error("reserved opcode cost wrong");
  real_illegal_a: assert property (in_valid && !prot_mode && ib0 == OP_ESC
    && (ib1 == OP_SEG_LIMIT || (ib1 == OP_GRP_SYS && ib2[5:3] == 3'h3)) |=> dec_invalid)
    else $error("protected-only form accepted in real mode");
  not_flags_a: assert property (in_valid && ib0[7:1] == OP_GRP_UNARY
    && ib1[5:3] == REG_NOT |=> !dec_flags_mod && dec_clk_max == 7'h01)
    else $error("complement cost or flags wrong");
  mul_dword_a: assert property (in_valid && ib0 == 8'hf7 && ib1[5:3] == REG_UMUL
    |=> dec_clk_max == ($past(opsize32) ? 7'h0a : 7'h04)) else $error("multiply count wrong");
endmodule

bind xod_decoder xod_decoder_assertions u_chk (.clk(clk), .rst(rst), .in_valid(in_valid),
  .in_ready(in_ready), .ib0(ib0), .ib1(ib1), .ib2(ib2), .prot_mode(prot_mode),
  .opsize32(opsize32), .dec_valid(dec_valid), .dec_hit(dec_hit), .dec_invalid(dec_invalid),
  .dec_class(dec_class), .dec_clk_min(dec_clk_min), .dec_clk_max(dec_clk_max),
  .dec_flags_mod(dec_flags_mod), .dec_insn_len(dec_insn_len));

// File: test/xod_fetch_model.sv
// Purpose: fetch and issue model feeding the decoder
// Assumes: one whole instruction per request
// Notes:   idle byte lanes show the inverse of their last value
`timescale 1ns/10ps

module xod_fetch_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // request from bench
  input  wire logic        req,
  input  wire logic [23:0] req_bytes,
  input  wire logic [2:0]  req_mode,
  // issue to decoder
  output logic             in_valid,
  output logic [7:0]       ib0,
  output logic [7:0]       ib1,
  output logic [7:0]       ib2,
  output logic             prot_mode,
  output logic             opsize32,
  output logic             addrsize32
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      in_valid <= 1'b0;
      {ib0, ib1, ib2} <= 24'h0;
      {prot_mode, opsize32, addrsize32} <= 3'h0;
    end else begin
      in_valid <= req;
      // toggling lanes so a stale byte never looks live
      {ib0, ib1, ib2} <= req ? req_bytes : ~{ib0, ib1, ib2};
      if (req) {prot_mode, opsize32, addrsize32} <= req_mode;
    end
  end
endmodule

// File: test/x86_opcode_cycle_decoder_tb.sv
// Purpose: self-checking bench for the opcode decoder
// Assumes: fetch model adds one cycle before the decoder
// Notes:   expectations queued at the taking edge, compared mid-cycle
`timescale 1ns/10ps

module x86_opcode_cycle_decoder_tb;
  import xod_pkg::*;
  logic        clk = 1'b0;
  logic        rst, req, in_valid, in_ready, prot_mode, opsize32, addrsize32;
  logic [23:0] req_bytes;
  logic [2:0]  req_mode, dec_opnd_len, dec_imm_len, dec_disp_len;
  logic [7:0]  ib0, ib1, ib2;
  logic        dec_valid, dec_hit, dec_invalid, dec_flags_mod, dec_has_modrm;
  xod_class_t  dec_class;
  logic [6:0]  dec_clk_min, dec_clk_max;
  logic [3:0]  dec_insn_len;
  logic [30:0] q[$];
  logic [30:0] ev;
  int          error_cnt = 0;
  int          check_count = 0;
  int          cycles = 0;

  always #10 clk = ~clk;

  xod_fetch_model u_fetch (.clk(clk), .rst(rst), .req(req), .req_bytes(req_bytes),
    .req_mode(req_mode), .in_valid(in_valid), .ib0(ib0), .ib1(ib1), .ib2(ib2),
    .prot_mode(prot_mode), .opsize32(opsize32), .addrsize32(addrsize32));
  xod_decoder dut (.clk(clk), .rst(rst), .in_valid(in_valid), .in_ready(in_ready),
    .ib0(ib0), .ib1(ib1), .ib2(ib2), .prot_mode(prot_mode), .opsize32(opsize32),
    .addrsize32(addrsize32), .dec_valid(dec_valid), .dec_hit(dec_hit),
    .dec_invalid(dec_invalid), .dec_class(dec_class), .dec_clk_min(dec_clk_min),
    .dec_clk_max(dec_clk_max), .dec_flags_mod(dec_flags_mod), .dec_has_modrm(dec_has_modrm),
    .dec_opnd_len(dec_opnd_len), .dec_imm_len(dec_imm_len), .dec_disp_len(dec_disp_len),
    .dec_insn_len(dec_insn_len));

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [6:0] seen, input logic [6:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic send(input logic [23:0] b, input logic [2:0] md);
    req <= 1'b1;
    req_bytes <= b;
    req_mode <= md;
    @(posedge clk);
  endtask

  // one instruction of form f, r fills the free fields
  function automatic logic [23:0] mk(input int f, input logic [7:0] r);
    logic [2:0] ce, de, te;
    ce = (r[7:6] == 2'h0) ? 3'h0 : (r[7] ? 3'h3 : 3'h2);
    de = r[5] ? {2'h3, r[3]} : {1'h0, r[4:3]};
    te = 3'h3 + 3'(r[5:3] % 5);
    case (f)
      0: return {16'h0f03, r};
      1: return {16'h0fb2, r};
      2: return {16'h0f00, r[7:6], 3'h3, r[2:0]};
      3: return {16'h0f22, 2'h3, ce, r[2:0]};
      4: return {16'h0f20, 2'h3, ce, r[2:0]};
      5: return {16'h0f23, 2'h3, de, r[2:0]};
      6: return {16'h0f21, 2'h3, de, r[2:0]};
      7: return {16'h0f26, 2'h3, te, r[2:0]};
      8: return {16'h0f24, 2'h3, te, r[2:0]};
      9: return {16'h0fff, r};
      10: return {8'h0f, 4'hb, r[7], 2'h3, r[6], r};
      11: return {6'h22, r[1:0], 2'h3, r[5:0], 8'h00};
      12: return {6'h23, r[7], 1'h0, r[7:6], 3'(r[5:3] % 6), r[2:0], 8'h00};
      13: return {4'hb, r[3:0], r, r};
      14: return {6'h28, r[1:0], r, r};
      15: return {7'h7b, r[0], r[7:6], 3'h4, r[2:0], 8'h00};
      17: return {8'h90, r, r};
      default: return {7'h7b, r[0], r[7:6], 3'h2, r[2:0], 8'h00};
    endcase
  endfunction

  // {hit, modrm, length, invalid, flags, min, max, operand, immediate, displacement}
  // an operand of 7 means unchecked; 90 is outside the slice
  function automatic logic [30:0] exp_of(input logic [23:0] b, input logic [2:0] md);
    logic [7:0] o, p, m;
    logic [2:0] e, op, im, dp;
    logic [6:0] mn, mx;
    logic [3:0] il;
    logic       inv, fl, pm, os, ht, hm;
    {o, p} = b[23:8];
    e = b[5:3];
    {pm, os} = md[2:1];
    {inv, fl, mn, op, im, dp} = {2'h0, 7'h01, 3'h7, 6'h00};
    ht = (o != 8'h90);
    hm = (o == 8'h0f) ? (p != 8'hff) : (o[7:4] == 4'h8 || o[7:4] == 4'hf);
    m = (o == 8'h0f) ? b[7:0] : b[15:8];
    if (o == 8'h0f) begin
      case (p)
        8'h03: {inv, fl, mn} = {!pm, 1'h1, pm ? 7'h08 : 7'h01};
        8'hb2: mn = pm ? 7'h04 : 7'h02;
        8'h00: {inv, mn} = {!pm, pm ? 7'h07 : 7'h01};
        8'h22: mn = (e == 3'h0) ? 7'h14 : 7'h05;
        8'h20: mn = 7'h06;
        8'h23: mn = 7'h10;
        8'h21: mn = 7'h0e;
        8'h26: mn = 7'h0a;
        8'h24: mn = (e < 3'h6) ? 7'h05 : 7'h06;
        8'hff: {inv, fl, mn} = {2'h3, pm ? 7'h08 : 7'h01};
        default: ;
      endcase
    end else if (o[7:2] == 6'h22) op = o[0] ? (os ? 3'h4 : 3'h2) : 3'h1;
    else if (o[7:4] == 4'hb) im = o[3] ? (os ? 3'h4 : 3'h2) : 3'h1;
    else if (o[7:2] == 6'h28) dp = md[0] ? 3'h4 : 3'h2;
    else if (o[7:1] == 7'h7b && p[5:3] == 3'h4) {fl, mn} = {1'h1, (o[0] && os) ? 7'h0a : 7'h04};
    mx = mn;
    if (o == 8'h0f && p == 8'hff && pm) mx = 7'h7d;
    if (o == 8'h8e && pm) mx = 7'h03;
    if (!ht) op = 3'h0;
    if (hm) begin
      case (m[7:6])
        2'h1: dp = 3'h1;
        2'h2: dp = md[0] ? 3'h4 : 3'h2;
        2'h0: begin
          if (md[0] && m[2:0] == 3'h5) dp = 3'h4;
          else if (!md[0] && m[2:0] == 3'h6) dp = 3'h2;
        end
        default: dp = 3'h0;
      endcase
    end
    il = ht ? ((o == 8'h0f) ? 4'h2 : 4'h1) + {3'h0, hm} + {1'b0, im} + {1'b0, dp} : 4'h0;
    return {ht, hm, il, inv, fl, mn, mx, op, im, dp};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (rst === 1'b0 && in_valid === 1'b1) q.push_back(exp_of({ib0, ib1, ib2},
      {prot_mode, opsize32, addrsize32}));
    if (cycles == 5000) begin
      error_cnt++;
      give_verdict();
    end
  end

  always @(negedge clk) begin
    if (rst !== 1'b0) q.delete();
    if (q.size() == 0) chk("dec_valid", {6'h0, dec_valid}, 7'h00);
    else begin
      ev = q.pop_front();
      chk("dec_valid", {6'h0, dec_valid}, 7'h01);
      chk("dec_hit", {6'h0, dec_hit}, {6'h0, ev[30]});
      chk("dec_has_modrm", {6'h0, dec_has_modrm}, {6'h0, ev[29]});
      chk("dec_insn_len", {3'h0, dec_insn_len}, {3'h0, ev[28:25]});
      chk("dec_invalid", {6'h0, dec_invalid}, {6'h0, ev[24]});
      chk("dec_flags_mod", {6'h0, dec_flags_mod}, {6'h0, ev[23]});
      chk("dec_clk_min", dec_clk_min, ev[22:16]);
      chk("dec_clk_max", dec_clk_max, ev[15:9]);
      if (ev[8:6] != 3'h7) chk("dec_opnd_len", {4'h0, dec_opnd_len}, {4'h0, ev[8:6]});
      if (ev[5:3] != 3'h7) chk("dec_imm_len", {4'h0, dec_imm_len}, {4'h0, ev[5:3]});
      if (ev[2:0] != 3'h7) chk("dec_disp_len", {4'h0, dec_disp_len}, {4'h0, ev[2:0]});
    end
  end

  initial begin
    int f, k;
    rst = 1'b1;
    req = 1'b0;
    req_bytes = 24'h0;
    req_mode = 3'h0;
    void'($urandom(32'hc21593db));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // every form in every mode, back to back
    for (k = 0; k < 8; k++) begin
      for (f = 0; f < 18; f++) send(mk(f, 8'hc0), 3'(k));
    end
    for (k = 0; k < 1500; k++) begin
      if (k == 700) begin
        req <= 1'b0;
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
      end
      if ($urandom_range(3) == 0) begin
        req <= 1'b0;
        @(posedge clk);
      end
      send(mk($urandom_range(17), 8'($urandom)), 3'($urandom));
    end
    req <= 1'b0;
    repeat (4) @(posedge clk);
    give_verdict();
  end
endmodule
